// File: tb/seie_link_props.sv
// Checker for the link data line and the device write cycle.
// Assumes plain link signals and device status, all sampled on clk.
`timescale 1ns/100ps
`default_nettype none
module seie_link_props #(
  parameter int unsigned WRITE_CLKS = 40 // Write time in clk cycles
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic busy,
  input wire logic commit_done
);
  logic sda_q; // Data line one clk ago
  logic [15:0] busy_cnt_q; // Length of the running write
  logic [3:0] since_stop_q; // Clks since Stop, saturates
  logic poll_q; // Last Start came while the write cycle ran
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Start: data falls while the clock stands high
  sequence start_s;
    scl && !sda && sda_q;
  endsequence
  sequence wr_start_s;
    !busy ##1 busy;
  endsequence
  // Helpers; a plain register avoids $past at reset release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sda_q <= 1'b1;
      busy_cnt_q <= 16'h0000;
      since_stop_q <= 4'hf;
      poll_q <= 1'b0;
    end else begin
      sda_q <= sda;
      // Each Start decides whether its select byte may be answered
      if (scl && !sda && sda_q) begin
        poll_q <= busy;
      end
      busy_cnt_q <= busy ? busy_cnt_q + 16'h0001 : 16'h0000;
      if (scl && sda && !sda_q) begin
        since_stop_q <= 4'h0;
      end else if (since_stop_q != 4'hf) begin
        since_stop_q <= since_stop_q + 4'h1;
      end
    end
  end
  busy_len_a: assert property ($fell(busy) |-> busy_cnt_q == WRITE_CLKS)
    else $error("write cycle length wrong");
  stop_busy_a: assert property ($rose(busy) |-> since_stop_q <= 4'h4)
    else $error("write cycle without a fresh stop");
  busy_hold_a: assert property (wr_start_s |=> busy [*8])
    else $error("write cycle ended too soon");
  commit_end_a: assert property ($fell(busy) |-> ##[0:1] commit_done)
    else $error("no commit at end of write");
  commit_cause_a: assert property (commit_done |-> !busy && ($past(busy) || $past(busy, 2)))
    else $error("commit without write cycle");
  busy_quiet_a: assert property (busy |-> !d_sda_oe)
    else $error("device drives data while busy");
  sel_busy_a: assert property ((start_s and busy) |=> !d_sda_oe [*8])
    else $error("select answered while busy");
  poll_nack_a: assert property (poll_q |-> !d_sda_oe)
    else $error("polling select acknowledged during write cycle");
  oe_scl_low_a: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device data moved with clock high");
  dev_od_a: assert property (d_sda_oe |-> !d_sda_o)
    else $error("device drives data high");
endmodule : seie_link_props
`default_nettype wire

// File: tb/tb_top.sv
// Testbench: master and device joined by the link, driven from the request side.
// Assumes the design package and link interface are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned WCLK = 40; // Short write time, still above a page
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0;
  seie_pkg::seie_op_t req_op = seie_pkg::OP_WRITE;
  logic [seie_pkg::ADDR_W-1:0] req_addr = 12'h000;
  logic [seie_pkg::LEN_W-1:0] req_len = 6'h01;
  logic [7:0] wr_data = 8'h00;
  logic req_ready, wr_take, rd_valid, done, busy, commit_done;
  logic [7:0] rd_data;
  logic [7:0] wq [$]; // Bytes to hand over
  logic [7:0] rq [$]; // Bytes received
  int wi = 0; // Write bytes taken so far
  int busy_rises = 0; // Write cycles started
  int starts = 0; // Start conditions in the current request
  logic busy_d = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  seie_link_if link ();
  always #50 clk = ~clk;
  seie_master u_seie_master (.clk(clk), .sys_rst(sys_rst), .link(link), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .req_ready(req_ready),
    .wr_data(wr_data), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid), .done(done));
  seie_device #(.WRITE_CLKS(WCLK)) u_seie_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .busy(busy), .commit_done(commit_done));
  seie_link_props #(.WRITE_CLKS(WCLK)) u_seie_link_props (.clk(clk), .sys_rst(sys_rst),
    .scl(link.scl), .sda(link.sda), .d_sda_o(link.d_sda_o), .d_sda_oe(link.d_sda_oe),
    .busy(busy), .commit_done(commit_done));
  // Collect read bytes, count takes and write cycles; looked at on the
  // falling edge, where the registered pulses have settled
  always @(negedge clk) begin
    if (rd_valid === 1'b1) rq.push_back(rd_data);
    if (wr_take === 1'b1) wi++;
    if (busy === 1'b1 && busy_d !== 1'b1) busy_rises++;
    busy_d = busy;
    wr_data <= (wi < wq.size()) ? wq[wi] : 8'h00; // Next write byte, off the sampling edge
  end
  // Count Start conditions on the link, to see polling
  always @(negedge link.sda) begin
    if (link.scl === 1'b1) starts++;
  end
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // One request, then wait for done; bounded waits end the run
  task automatic do_req(input seie_pkg::seie_op_t op, input logic [11:0] a, input int n);
    int k = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 1000) begin
      num_errors++;
      close_out();
    end
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_len = 6'(n);
    @(negedge clk);
    req_valid = 1'b0;
    // Polling on a busy device may take many frames
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k >= 20000) begin
      num_errors++;
      close_out();
    end
  endtask : do_req
  task automatic rd(input seie_pkg::seie_op_t op, input logic [11:0] a, input logic [7:0] exp [$]);
    rq = {};
    starts = 0;
    do_req(op, a, exp.size());
    chk("read count", 8'(rq.size()), 8'(exp.size()));
    foreach (exp[i]) chk("read byte", rq[i], exp[i]);
    $display("read test done, %0d checks", samples_checked);
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] d [$]);
    wq = d;
    wi = 0;
    busy_rises = 0;
    do_req(seie_pkg::OP_WRITE, a, d.size());
    chk("bytes taken", 8'(wi), 8'(d.size()));
    $display("write test done, %0d checks", samples_checked);
  endtask : wr
  // Main sequence
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    rd(seie_pkg::OP_RAND_READ, 12'hffe, '{8'hff, 8'hff});
    chk("starts in random read", 8'(starts), 8'h02);
    chk("no write after read", 8'(busy_rises), 8'h00);
    wr(12'h01e, '{8'ha0, 8'ha1, 8'ha2, 8'ha3});
    rd(seie_pkg::OP_RAND_READ, 12'h01e, '{8'ha0});
    chk("select polled", 8'(starts > 2), 8'h01);
    chk("write cycles", 8'(busy_rises), 8'h01);
    rd(seie_pkg::OP_CUR_READ, 12'h000, '{8'ha1, 8'hff});
    rd(seie_pkg::OP_RAND_READ, 12'hfff, '{8'hff, 8'ha2, 8'ha3});
    wr(12'h7ff, '{8'h5c});
    rd(seie_pkg::OP_RAND_READ, 12'h7ff, '{8'h5c, 8'hff});
    close_out();
  end
endmodule : tb_top
`default_nettype wire

// File: verilog/seie_cond_det.sv
// Start and Stop detector clocked by the data line itself.
// Assumes scl is steady high around a Start or Stop edge.
`timescale 1ns/100ps
`default_nettype none
module seie_cond_det (
  input wire logic scl,
  input wire logic sda,
  input wire logic sys_rst,
  output logic start_tog,
  output logic stop_tog
);
  // Data line is the only clock here and does not move during reset,
  // so these two flops are reset without a clock edge
  always_ff @(negedge sda or posedge sys_rst) begin
    if (sys_rst) begin
      start_tog <= 1'b0;
    end else if (scl) begin
      start_tog <= !start_tog; // Falling data with clock high
    end
  end

  // Rising data with clock high marks a Stop
  always_ff @(posedge sda or posedge sys_rst) begin
    if (sys_rst) begin
      stop_tog <= 1'b0;
    end else if (scl) begin
      stop_tog <= !stop_tog;
    end
  end
endmodule : seie_cond_det
`default_nettype wire

// File: verilog/seie_device.sv
// Device end: serial slave, page latch, self-timed write cycle and byte array.
// Assumes the master delivers scl edges while sys_rst is high and for a few
// edges after it, so the link side reset takes effect.
`timescale 1ns/100ps
`default_nettype none
module seie_device #(
  parameter int unsigned WRITE_CLKS = seie_pkg::WRITE_CLKS_DEF // Internal write time in clk cycles
) (
  input wire logic clk,
  input wire logic sys_rst,
  seie_link_if.device link,
  output logic busy,
  output logic commit_done
);
  localparam logic [31:0] WRITE_LAST = 32'(WRITE_CLKS - 1);
  localparam logic [31:0] PAGE_LAST = 32'(seie_pkg::PAGE_BYTES);

  // Link side state, clocked on rising scl
  typedef struct packed {
    logic rst1; // Reset sync, first stage
    logic rst2; // Reset sync, second stage
    logic bsy1; // Busy sync, first stage
    logic bsy2; // Busy sync, second stage
    logic seen_start; // Last Start toggle acted on
    logic seen_stop; // Last Stop toggle acted on
    seie_pkg::seie_dl_t st; // Byte role
    logic [3:0] cnt; // Bits seen in this byte, 8 in ack slot
    logic [7:0] sh; // Received bits
    logic ack; // Pull low in the coming ack slot
    logic gotd; // Previous byte was an acked data byte
    logic armed; // A Stop now would start a write
    logic deaf; // Busy seen at some bit of this select byte
    logic [seie_pkg::ADDR_W-1:0] addr; // Internal address counter
    logic [seie_pkg::PAGE_BYTES-1:0] mask; // Latched page bytes
    logic [seie_pkg::PAGE_BYTES-1:0][7:0] latch; // Page latch
    logic [7:0] tx; // Byte being sent
  } seie_dl_s_t;

  // Drive side, clocked on falling scl so data changes while scl is low
  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } seie_drv_t;

  // System clock side: write timer and array
  typedef struct packed {
    logic stp1; // Stop toggle sync
    logic stp2;
    logic stp3; // Previous synced value, for edge detection
    logic arm1; // Armed level sync
    logic arm2;
    logic busy;
    logic done;
    logic [31:0] cnt; // Write cycle timer
    logic [seie_pkg::MEM_BYTES-1:0][7:0] mem;
  } seie_dc_t;

  seie_dl_s_t q, d;
  seie_drv_t qv, dv;
  seie_dc_t qc, dc;
  logic start_tog;
  logic stop_tog;
  logic new_start;
  logic new_stop;
  logic [7:0] rx_byte;

  // Start and Stop seen on data edges
  seie_cond_det u_cond (
    .scl(link.scl),
    .sda(link.sda),
    .sys_rst(sys_rst),
    .start_tog(start_tog),
    .stop_tog(stop_tog)
  );

  // The condition toggles settle at least half a bit before the next rising
  // scl, so they are read directly; a sync stage would swallow the first bit.
  // The data pin itself is sampled on rising scl, the protocol's own timing.
  always_comb begin
    d = q;
    d.rst1 = sys_rst;
    d.rst2 = q.rst1;
    d.bsy1 = qc.busy;
    d.bsy2 = q.bsy1;
    d.seen_start = start_tog;
    d.seen_stop = stop_tog;
    new_start = (start_tog != q.seen_start);
    new_stop = (stop_tog != q.seen_stop);
    rx_byte = {q.sh[6:0], link.sda};
    if (q.rst2) begin
      // Standby after reset
      d.st = seie_pkg::DL_IDLE;
      d.cnt = '0;
      d.ack = 1'b0;
      d.gotd = 1'b0;
      d.deaf = 1'b0;
      d.addr = '0;
      d.mask = '0;
    end else if (new_start) begin
      // First bit of a select byte
      d.st = seie_pkg::DL_SEL;
      d.cnt = seie_pkg::SLOT_FIRST;
      d.sh = {7'h00, link.sda};
      // A Start during the write cycle must not be answered later in the byte,
      // even when the cycle ends before the ack slot
      d.deaf = q.bsy2;
      d.ack = 1'b0;
      d.gotd = 1'b0;
    end else if (new_stop) begin
      // Stop was seen earlier; back to standby
      d.st = seie_pkg::DL_IDLE;
      d.cnt = '0;
      d.ack = 1'b0;
    end else if (q.st != seie_pkg::DL_IDLE) begin
      if (q.cnt != seie_pkg::SLOT_ACK) begin
        // Data bit
        d.sh = rx_byte;
        d.cnt = q.cnt + 4'h1;
        // The busy sync lags two scl edges, so collect it over the whole byte
        d.deaf = q.deaf || q.bsy2;
        if (d.cnt == seie_pkg::SLOT_SECOND) begin
          d.gotd = 1'b0;
        end
        if (d.cnt == seie_pkg::SLOT_ACK) begin
          unique case (q.st)
            seie_pkg::DL_SEL: d.ack = (rx_byte[7:1] == seie_pkg::SEL_CODE) && !q.bsy2 && !q.deaf;
            seie_pkg::DL_AH, seie_pkg::DL_AL, seie_pkg::DL_WDATA: d.ack = 1'b1;
            default: d.ack = 1'b0; // Master answers after a read byte
          endcase
        end
      end else begin
        // Ack slot
        d.cnt = '0;
        d.ack = 1'b0;
        unique case (q.st)
          seie_pkg::DL_SEL: begin
            if (!q.ack) begin
              d.st = seie_pkg::DL_IDLE; // Busy or not ours
            end else if (q.sh[0]) begin
              d.st = seie_pkg::DL_RDATA;
              d.tx = qc.mem[q.addr];
            end else begin
              d.st = seie_pkg::DL_AH;
              d.mask = '0; // Fresh page latch for a new write
            end
          end
          seie_pkg::DL_AH: begin
            // High byte first; bits above the array are ignored
            d.addr[seie_pkg::ADDR_W-1:8] = q.sh[seie_pkg::ADDR_W-9:0];
            d.st = seie_pkg::DL_AL;
          end
          seie_pkg::DL_AL: begin
            d.addr[7:0] = q.sh;
            d.st = seie_pkg::DL_WDATA;
          end
          seie_pkg::DL_WDATA: begin
            // Latch and advance inside the page only
            d.latch[q.addr[seie_pkg::PAGE_W-1:0]] = q.sh;
            d.mask[q.addr[seie_pkg::PAGE_W-1:0]] = 1'b1;
            d.addr[seie_pkg::PAGE_W-1:0] = q.addr[seie_pkg::PAGE_W-1:0] + 5'h01;
            d.gotd = 1'b1;
          end
          seie_pkg::DL_RDATA: begin
            d.addr = q.addr + 12'h001;
            if (link.sda) begin
              d.st = seie_pkg::DL_IDLE;
            end else begin
              d.tx = qc.mem[d.addr];
            end
          end
          default: d.st = seie_pkg::DL_IDLE;
        endcase
      end
    end
    // Clock pulse of the 10th slot right after a data ack
    d.armed = (d.st == seie_pkg::DL_WDATA) && (d.cnt == seie_pkg::SLOT_FIRST) && d.gotd;
  end

  always_ff @(posedge link.scl) begin
    q <= d;
  end

  // Pull low for ack or a zero bit; never while the write cycle runs
  always_comb begin
    dv.sda_o = 1'b0;
    dv.sda_oe = 1'b0;
    if (!q.rst2 && !q.bsy2) begin
      if (q.cnt == seie_pkg::SLOT_ACK) begin
        dv.sda_oe = q.ack;
      end else if (q.st == seie_pkg::DL_RDATA) begin
        dv.sda_oe = !q.tx[3'(seie_pkg::BIT_MSB - q.cnt)];
      end
    end
  end

  always_ff @(negedge link.scl) begin
    qv <= dv;
  end

  // Write cycle: Stop toggle and armed level cross by two flops each; the
  // page latch is only read while it cannot change, because the link side
  // refuses every select during busy. Likewise the link only reads the array
  // outside busy. Needs WRITE_CLKS of at least one page.
  always_comb begin
    dc = qc;
    dc.stp1 = stop_tog;
    dc.stp2 = qc.stp1;
    dc.stp3 = qc.stp2;
    dc.arm1 = q.armed;
    dc.arm2 = qc.arm1;
    dc.done = 1'b0;
    if (sys_rst) begin
      dc.busy = 1'b0;
      dc.cnt = '0;
      for (int i = 0; i < seie_pkg::MEM_BYTES; i++) begin
        dc.mem[i] = seie_pkg::ERASED_BYTE;
      end
    end else if (!qc.busy) begin
      if ((qc.stp2 != qc.stp3) && qc.arm2) begin
        dc.busy = 1'b1;
        dc.cnt = '0;
      end
    end else begin
      // One latched byte per cycle, all of one page
      if (qc.cnt < PAGE_LAST && q.mask[qc.cnt[seie_pkg::PAGE_W-1:0]]) begin
        dc.mem[{q.addr[seie_pkg::ADDR_W-1:seie_pkg::PAGE_W], qc.cnt[seie_pkg::PAGE_W-1:0]}] =
          q.latch[qc.cnt[seie_pkg::PAGE_W-1:0]];
      end
      dc.cnt = qc.cnt + 32'h1;
      if (qc.cnt == WRITE_LAST) begin
        dc.busy = 1'b0;
        dc.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    qc <= dc;
  end

  assign link.d_sda_o = qv.sda_o;
  assign link.d_sda_oe = qv.sda_oe;
  assign busy = qc.busy;
  assign commit_done = qc.done;
endmodule : seie_device
`default_nettype wire

// File: verilog/seie_link_if.sv
// Two-wire link between the master end and the device end.
// Assumes open-drain data: a driver with enable high and output low pulls it low.
`timescale 1ns/100ps
`default_nettype none
interface seie_link_if;
  logic scl; // Serial clock, pushed by the master
  logic m_sda_o; // Master data output
  logic m_sda_oe; // Master data enable
  logic d_sda_o; // Device data output
  logic d_sda_oe; // Device data enable
  logic sda; // Resolved data line, pulled up when nobody pulls low
  assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));
  modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
  modport device (input scl, input sda, output d_sda_o, output d_sda_oe);
endinterface : seie_link_if
`default_nettype wire

// File: verilog/seie_master.sv
// Master end: makes scl from clk, runs write, random read and current read.
// Assumes the device end on the same link; one request at a time.
`timescale 1ns/100ps
`default_nettype none
module seie_master (
  input wire logic clk,
  input wire logic sys_rst,
  seie_link_if.master link,
  input wire logic req_valid,
  input wire seie_pkg::seie_op_t req_op,
  input wire logic [seie_pkg::ADDR_W-1:0] req_addr,
  input wire logic [seie_pkg::LEN_W-1:0] req_len,
  output logic req_ready,
  input wire logic [7:0] wr_data,
  output logic wr_take,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic done
);
  localparam logic [7:0] QTR_LAST = 8'(seie_pkg::SCL_QTR_CLKS - 1);

  typedef struct packed {
    logic s1; // Data pin sync, first stage
    logic s2;
    seie_pkg::seie_ms_t st;
    seie_pkg::seie_step_t step;
    seie_pkg::seie_op_t op;
    logic [1:0] ph; // Quarter of the bit
    logic [7:0] div; // Quarter timer
    logic [3:0] bitn; // Bit in byte, 8 is ack slot
    logic [7:0] sh;
    logic [seie_pkg::LEN_W-1:0] cnt; // Bytes left
    logic [seie_pkg::ADDR_W-1:0] addr;
    logic [2:0] warm; // Idle scl toggles still owed to the device reset
    logic miss; // No ack seen
    logic scl;
    logic sda_o;
    logic sda_oe;
    logic ready;
    logic take;
    logic [7:0] rdat;
    logic rval;
    logic done;
  } seie_m_t;

  seie_m_t q, d;
  logic tick;

  // One quarter-bit sequencer; each bit is low, rise, sample, fall
  always_comb begin
    d = q;
    d.s1 = link.sda;
    d.s2 = q.s1;
    d.take = 1'b0;
    d.rval = 1'b0;
    d.done = 1'b0;
    tick = (q.div == QTR_LAST);
    d.div = tick ? 8'h00 : q.div + 8'h01;
    if (sys_rst) begin
      // Toggle scl so the device link side sees its reset
      d = '0;
      d.scl = !q.scl;
      d.warm = seie_pkg::WARM_TOGGLES;
    end else if (q.st == seie_pkg::MS_IDLE) begin
      if (q.warm != 3'h0) begin
        if (tick) begin
          d.scl = !q.scl;
          d.warm = q.warm - 3'h1;
        end
      end else begin
        d.scl = 1'b1;
        d.ready = !(req_valid && q.ready);
        if (req_valid && q.ready) begin
          d.op = req_op;
          d.addr = req_addr;
          d.cnt = req_len;
          d.st = seie_pkg::MS_START;
          d.ph = '0;
          d.div = '0;
          d.step = (req_op == seie_pkg::OP_CUR_READ) ? seie_pkg::SP_SELR : seie_pkg::SP_SELW;
        end
      end
    end else if (tick) begin
      d.ph = q.ph + 2'h1;
      unique case (q.st)
        seie_pkg::MS_START: begin
          unique case (q.ph)
            2'h0: begin
              d.scl = 1'b0;
              d.sda_oe = 1'b0;
            end
            2'h1: d.scl = 1'b1;
            2'h2: d.sda_oe = 1'b1; // Start or repeated Start
            default: begin
              d.scl = 1'b0;
              d.st = seie_pkg::MS_BIT;
              d.bitn = '0;
              d.sh = seie_pkg::sel_byte(q.step == seie_pkg::SP_SELR);
            end
          endcase
        end
        seie_pkg::MS_BIT: begin
          unique case (q.ph)
            2'h0: begin
              if (q.bitn == seie_pkg::SLOT_ACK) begin
                d.sda_oe = (q.step == seie_pkg::SP_RD) && (q.cnt != 6'h01);
              end else begin
                d.sda_oe = (q.step != seie_pkg::SP_RD) && !q.sh[7];
              end
            end
            2'h1: d.scl = 1'b1;
            2'h2: begin
              if (q.bitn == seie_pkg::SLOT_ACK) begin
                d.miss = q.s2;
              end else begin
                d.sh = {q.sh[6:0], q.s2};
              end
            end
            default: begin
              d.scl = 1'b0;
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == seie_pkg::SLOT_ACK) begin
                d.bitn = '0;
                unique case (q.step)
                  seie_pkg::SP_SELW: begin
                    if (q.miss) begin
                      d.st = seie_pkg::MS_START; // Still busy, poll again
                    end else begin
                      d.step = seie_pkg::SP_AH;
                      d.sh = 8'(q.addr[seie_pkg::ADDR_W-1:8]);
                    end
                  end
                  seie_pkg::SP_AH: begin
                    d.step = seie_pkg::SP_AL;
                    d.sh = q.addr[7:0];
                    if (q.miss) d.st = seie_pkg::MS_STOP;
                  end
                  seie_pkg::SP_AL: begin
                    if (q.miss) begin
                      d.st = seie_pkg::MS_STOP;
                    end else if (q.op == seie_pkg::OP_WRITE) begin
                      d.step = seie_pkg::SP_WD;
                      d.sh = wr_data;
                      d.take = 1'b1;
                    end else begin
                      d.st = seie_pkg::MS_START; // Dummy write ends with no Stop
                      d.step = seie_pkg::SP_SELR;
                    end
                  end
                  seie_pkg::SP_WD: begin
                    d.cnt = q.cnt - 6'h01;
                    if (q.miss || q.cnt == 6'h01) begin
                      d.st = seie_pkg::MS_STOP;
                    end else begin
                      d.sh = wr_data;
                      d.take = 1'b1;
                    end
                  end
                  seie_pkg::SP_SELR: begin
                    if (q.miss) begin
                      d.st = seie_pkg::MS_START;
                    end else begin
                      d.step = seie_pkg::SP_RD;
                    end
                  end
                  default: begin
                    d.rdat = q.sh;
                    d.rval = 1'b1;
                    d.cnt = q.cnt - 6'h01;
                    if (q.cnt == 6'h01) d.st = seie_pkg::MS_STOP;
                  end
                endcase
              end
            end
          endcase
        end
        default: begin
          // Stop: data low, clock high, then release data
          unique case (q.ph)
            2'h0: begin
              d.scl = 1'b0;
              d.sda_oe = 1'b1;
            end
            2'h1: d.scl = 1'b1;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              d.st = seie_pkg::MS_IDLE;
              d.ready = 1'b1;
              d.done = 1'b1;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    q <= d;
  end

  assign link.scl = q.scl;
  assign link.m_sda_o = q.sda_o;
  assign link.m_sda_oe = q.sda_oe;
  assign req_ready = q.ready;
  assign wr_take = q.take;
  assign rd_data = q.rdat;
  assign rd_valid = q.rval;
  assign done = q.done;
endmodule : seie_master
`default_nettype wire

// File: verilog/seie_pkg.sv
// Shared constants, types and helpers for the two-wire EEPROM instruction engine.
// Assumes a 10 MHz system clock; the serial clock is made by the master end.
package seie_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned MEM_BYTES = 4096;
  localparam int unsigned PAGE_BYTES = 32;
  localparam int unsigned PAGE_W = 5;
  localparam int unsigned LEN_W = 6;
  localparam logic [6:0] SEL_CODE = 7'h50;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_FIRST = 4'h1;
  localparam logic [3:0] SLOT_SECOND = 4'h2;
  localparam logic [3:0] BIT_MSB = 4'h7;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SCL_QTR_NS = 400;
  localparam int unsigned SCL_QTR_CLKS = (SCL_QTR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] WARM_TOGGLES = 3'h6;
  localparam int unsigned WRITE_CLKS_DEF = 1000;

  // Serial side of the device end
  typedef enum logic [2:0] {DL_IDLE, DL_SEL, DL_AH, DL_AL, DL_WDATA, DL_RDATA} seie_dl_t;
  // Master bit engine and byte roles
  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BIT, MS_STOP} seie_ms_t;
  typedef enum logic [2:0] {SP_SELW, SP_AH, SP_AL, SP_WD, SP_SELR, SP_RD} seie_step_t;
  typedef enum logic [1:0] {OP_WRITE, OP_RAND_READ, OP_CUR_READ} seie_op_t;

  // Select byte; the same seven upper bits for both directions
  function automatic logic [7:0] sel_byte(input logic rd);
    sel_byte = {SEL_CODE, rd};
  endfunction : sel_byte
endpackage : seie_pkg
